// [core/system_irq_enable_sequencing_regs.v]
// System interrupt mask, status, regulator enable and startup delay registers
//
// Operation
// - Mask bit 4 blocks watchdog irq, resets 1
// - Mask bit 3 blocks undervoltage irq, resets 0
// - Mask bit 2 blocks thermal-off irq, resets 0
// - Mask bit 1 blocks 140 degree irq, resets 1
// - Mask bit 0 blocks 120 degree irq; reset 0x13
// - Status bit 3 shows live undervoltage
// - Status bit 2 shows above 165 degrees
// - Status bit 1 shows above 140 degrees
// - Status bit 0 shows above 120 degrees
// - Output enable bits ORed with assigned input
// - Odd enable bits select low power mode
// - Enable control register resets to zero
// - Step select bit: 1 ms or 2 ms
// - Flag register latches every event, watchdog included
//
// Decided for this implementation: the AXI4-Lite register port.
`include "sys_irq_seq_map.vh"

module system_irq_enable_sequencing_regs #(
	parameter STEP_CYCLES = `STEP_BASE_CYCLES
) (
	input wire CORE_CLK_IN,
	input wire RESETN_IN,
	input wire [7:0] S_AXI_AWADDR_IN,
	input wire S_AXI_AWVALID_IN,
	output reg S_AXI_AWREADY_OUT,
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output reg S_AXI_WREADY_OUT,
	output reg [1:0] S_AXI_BRESP_OUT,
	output reg S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	input wire [7:0] S_AXI_ARADDR_IN,
	input wire S_AXI_ARVALID_IN,
	output reg S_AXI_ARREADY_OUT,
	output reg [31:0] S_AXI_RDATA_OUT,
	output reg [1:0] S_AXI_RRESP_OUT,
	output reg S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	input wire SUPPLY_UNDERVOLTAGE_IN,
	input wire THERMAL_OFF_IN,
	input wire HOT_HIGH_IN,
	input wire HOT_LOW_IN,
	input wire WATCHDOG_INPUT_IN,
	input wire ENABLE_PIN_IN,
	input wire [1:0] GENERAL_INPUT_PIN_IN,
	output reg [3:0] MASTER_OUTPUT_ON_OUT,
	output reg [3:0] MASTER_START_OUT,
	output reg [3:0] MASTER_LOW_POWER_OUT,
	output reg IRQ_OUT
);

	// Pin synchronisers: first stage read only by second
	localparam PIN_COUNT = 8;
	wire [PIN_COUNT-1:0] pin_raw;
	reg [PIN_COUNT-1:0] pin_meta_r;
	reg [PIN_COUNT-1:0] pin_sync_r;
	assign pin_raw = {GENERAL_INPUT_PIN_IN, ENABLE_PIN_IN, WATCHDOG_INPUT_IN,
		SUPPLY_UNDERVOLTAGE_IN, THERMAL_OFF_IN, HOT_HIGH_IN, HOT_LOW_IN};

	always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			pin_meta_r <= {PIN_COUNT{1'b0}};
			pin_sync_r <= {PIN_COUNT{1'b0}};
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	wire [`EVENT_COUNT-1:0] event_level;
	wire enable_pin_s;
	wire [1:0] general_input_s;
	assign event_level = pin_sync_r[4:0];
	assign enable_pin_s = pin_sync_r[5];
	assign general_input_s = pin_sync_r[7:6];

	// Registers
	reg [4:0] irq_mask_r;
	reg [4:0] irq_flags_r;
	reg [3:0] cond_status_r;
	reg [7:0] enable_ctrl_r;
	reg step_select_r;
	reg [4:0] master_two_start_wait_r;
	reg [4:0] master_three_start_wait_r;
	reg global_turn_on_r;
	reg [7:0] input_assign_r;
	reg [`EVENT_COUNT-1:0] event_prev_r;

	// Reset images; only the stored fields are kept
	localparam [7:0] MASK_RESET = `RST_IRQ_MASK;
	localparam [7:0] DLY_RESET = `RST_STARTUP_DLY;
	localparam [7:0] GLOBAL_RESET = `RST_GLOBAL_CTRL;

	// Write channel
	reg aw_held_r;
	reg w_held_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg w_lane0_r;
	wire wr_fire;
	wire [5:0] wr_index;
	wire wr_en;
	reg wr_mapped;

	assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID_OUT;
	assign wr_index = aw_addr_r[7:2];
	assign wr_en = wr_fire && w_lane0_r;

	// Read-only offsets answer OKAY and keep their contents
	always @* begin
		case ({2'h0, wr_index})
			`IDX_IRQ_MASK, `IDX_ENABLE_CTRL, `IDX_STARTUP_DLY_ONE, `IDX_STARTUP_DLY_TWO,
			`IDX_IRQ_CLEAR, `IDX_GLOBAL_CTRL, `IDX_INPUT_ASSIGN: begin
				wr_mapped = 1'b1;
			end
			`IDX_IRQ_FLAGS, `IDX_COND_STATUS: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_lane0_r <= 1'b0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT <= 1'b0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= `RESP_OKAY;
		end else begin
			S_AXI_AWREADY_OUT <= !aw_held_r && !S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT;
			S_AXI_WREADY_OUT <= !w_held_r && !S_AXI_WREADY_OUT && !S_AXI_BVALID_OUT;
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR_IN;
				S_AXI_AWREADY_OUT <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA_IN;
				w_lane0_r <= S_AXI_WSTRB_IN[0];
				S_AXI_WREADY_OUT <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
		end
	end

	// Register storage
	always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			irq_mask_r <= MASK_RESET[`EVENT_COUNT-1:0];
			enable_ctrl_r <= `RST_ENABLE_CTRL;
			step_select_r <= DLY_RESET[`BIT_STEP_SELECT];
			master_two_start_wait_r <= DLY_RESET[`DLY_FIELD_MSB:0];
			master_three_start_wait_r <= DLY_RESET[`DLY_FIELD_MSB:0];
			global_turn_on_r <= GLOBAL_RESET[`BIT_GLOBAL_TURN_ON];
			input_assign_r <= `RST_INPUT_ASSIGN;
		end else if (wr_en) begin
			case ({2'h0, wr_index})
				`IDX_IRQ_MASK: begin
					irq_mask_r <= w_data_r[4:0];
				end
				`IDX_ENABLE_CTRL: begin
					enable_ctrl_r <= w_data_r[7:0];
				end
				`IDX_STARTUP_DLY_ONE: begin
					step_select_r <= w_data_r[`BIT_STEP_SELECT];
					master_two_start_wait_r <= w_data_r[`DLY_FIELD_MSB:0];
				end
				`IDX_STARTUP_DLY_TWO: begin
					master_three_start_wait_r <= w_data_r[`DLY_FIELD_MSB:0];
				end
				`IDX_GLOBAL_CTRL: begin
					global_turn_on_r <= w_data_r[`BIT_GLOBAL_TURN_ON];
				end
				`IDX_INPUT_ASSIGN: begin
					input_assign_r <= w_data_r[7:0];
				end
				default: begin
					global_turn_on_r <= global_turn_on_r;
				end
			endcase
		end
	end

	// Live status and sticky flags
	wire [4:0] flag_clear;
	wire [4:0] event_rise;
	assign flag_clear = (wr_en && ({2'h0, wr_index} == `IDX_IRQ_CLEAR)) ? w_data_r[4:0] : 5'h00;
	assign event_rise = event_level & ~event_prev_r;

	always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cond_status_r <= 4'h0;
			event_prev_r <= {`EVENT_COUNT{1'b0}};
			irq_flags_r <= 5'h00;
			IRQ_OUT <= 1'b0;
		end else begin
			cond_status_r <= event_level[3:0];
			event_prev_r <= event_level;
			// An event in the clear's cycle keeps its flag
			irq_flags_r <= (irq_flags_r & ~flag_clear) | event_rise;
			IRQ_OUT <= |(irq_flags_r & ~irq_mask_r);
		end
	end

	// Read channel
	reg [7:0] rd_value;
	reg rd_mapped;
	wire [5:0] rd_index;
	assign rd_index = S_AXI_ARADDR_IN[7:2];

	always @* begin
		rd_value = 8'h00;
		rd_mapped = 1'b1;
		case ({2'h0, rd_index})
			`IDX_IRQ_FLAGS: begin
				rd_value = {3'h0, irq_flags_r};
			end
			`IDX_IRQ_MASK: begin
				rd_value = {3'h0, irq_mask_r};
			end
			`IDX_COND_STATUS: begin
				rd_value = {4'h0, cond_status_r};
			end
			`IDX_ENABLE_CTRL: begin
				rd_value = enable_ctrl_r;
			end
			`IDX_STARTUP_DLY_ONE: begin
				rd_value = {step_select_r, 2'h0, master_two_start_wait_r};
			end
			`IDX_STARTUP_DLY_TWO: begin
				rd_value = {3'h0, master_three_start_wait_r};
			end
			`IDX_IRQ_CLEAR: begin
				rd_value = 8'h00;
			end
			`IDX_GLOBAL_CTRL: begin
				rd_value = {7'h00, global_turn_on_r};
			end
			`IDX_INPUT_ASSIGN: begin
				rd_value = input_assign_r;
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h00000000;
			S_AXI_RRESP_OUT <= `RESP_OKAY;
		end else begin
			S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT;
			if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
				S_AXI_ARREADY_OUT <= 1'b0;
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT <= {24'h000000, rd_value};
				S_AXI_RRESP_OUT <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
				S_AXI_RVALID_OUT <= 1'b0;
			end
		end
	end

	// Sequencing: start on rise of pin or global turn-on
	reg seq_on_prev_r;
	reg [31:0] base_cnt_r;
	reg step_half_r;
	reg step_tick_r;
	wire seq_on;
	wire seq_start;
	wire base_tick;
	assign seq_on = enable_pin_s | global_turn_on_r;
	assign seq_start = seq_on && !seq_on_prev_r;
	assign base_tick = (base_cnt_r == STEP_CYCLES - 1);
	// Base count runs freely; a start realigns the first step

	always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			seq_on_prev_r <= 1'b0;
			base_cnt_r <= 32'h00000000;
			step_half_r <= 1'b0;
			step_tick_r <= 1'b0;
		end else begin
			seq_on_prev_r <= seq_on;
			step_tick_r <= 1'b0;
			if (seq_start) begin
				base_cnt_r <= 32'h00000000;
				step_half_r <= 1'b0;
			end else if (base_tick) begin
				base_cnt_r <= 32'h00000000;
				step_half_r <= !step_half_r;
				step_tick_r <= !step_select_r || step_half_r;
			end else begin
				base_cnt_r <= base_cnt_r + 32'h00000001;
			end
		end
	end

	// Masters one and four start without delay
	wire [4:0] wait_code [0:3];
	assign wait_code[0] = 5'h00;
	assign wait_code[1] = master_two_start_wait_r;
	assign wait_code[2] = master_three_start_wait_r;
	assign wait_code[3] = 5'h00;

	genvar m;
	generate
		for (m = 0; m < `MASTER_COUNT; m = m + 1) begin : master_g
			reg [4:0] wait_cnt_r;
			reg [1:0] sel;
			reg assigned_input;
			always @* begin
				sel = input_assign_r[2*m+1:2*m];
				case (sel)
					`ASSIGN_INPUT_ZERO: begin
						assigned_input = general_input_s[0];
					end
					`ASSIGN_INPUT_ONE: begin
						assigned_input = general_input_s[1];
					end
					default: begin
						assigned_input = 1'b0;
					end
				endcase
			end
			always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					wait_cnt_r <= 5'h00;
					MASTER_OUTPUT_ON_OUT[m] <= 1'b0;
					MASTER_LOW_POWER_OUT[m] <= 1'b0;
					MASTER_START_OUT[m] <= 1'b0;
				end else begin
					// Output enable is not gated by the start sequence
					MASTER_OUTPUT_ON_OUT[m] <= enable_ctrl_r[2*m] | assigned_input;
					MASTER_LOW_POWER_OUT[m] <= enable_ctrl_r[2*m+1];
					if (seq_start) begin
						wait_cnt_r <= wait_code[m];
					end else if (step_tick_r && wait_cnt_r != 5'h00) begin
						wait_cnt_r <= wait_cnt_r - 5'h01;
					end
					MASTER_START_OUT[m] <= seq_on && !seq_start && (wait_cnt_r == 5'h00);
				end
			end
		end
	endgenerate

endmodule // system_irq_enable_sequencing_regs

// [core/sys_irq_seq_map.vh]
// Register indices, field positions, reset values and timing counts
`ifndef SYS_IRQ_SEQ_MAP_VH
`define SYS_IRQ_SEQ_MAP_VH

// Register indices; byte address is four times the index
`define IDX_IRQ_FLAGS 8'h03
`define IDX_IRQ_MASK 8'h04
`define IDX_COND_STATUS 8'h05
`define IDX_ENABLE_CTRL 8'h06
`define IDX_STARTUP_DLY_ONE 8'h07
`define IDX_STARTUP_DLY_TWO 8'h08
`define IDX_IRQ_CLEAR 8'h10
`define IDX_GLOBAL_CTRL 8'h11
`define IDX_INPUT_ASSIGN 8'h12

// Reset values
`define RST_IRQ_MASK 8'h13
`define RST_ENABLE_CTRL 8'h00
`define RST_STARTUP_DLY 8'h00
`define RST_GLOBAL_CTRL 8'h00
`define RST_INPUT_ASSIGN 8'h00

// Event bit positions in flag, mask and status registers
`define BIT_HOT_LOW 0
`define BIT_HOT_HIGH 1
`define BIT_THERMAL_OFF 2
`define BIT_UNDERVOLTAGE 3
`define BIT_WATCHDOG 4
`define EVENT_COUNT 5

// Enable control layout: master k output at 2k, low power at 2k+1
`define MASTER_COUNT 4

// Startup delay fields
`define BIT_STEP_SELECT 7
`define DLY_FIELD_MSB 4
`define DLY_FIELD_WIDTH 5

// Global control and input assignment
`define BIT_GLOBAL_TURN_ON 0
`define ASSIGN_NONE 2'h0
`define ASSIGN_INPUT_ZERO 2'h1
`define ASSIGN_INPUT_ONE 2'h2

// Timing
`define CLK_PERIOD_NS 20
`define STEP_BASE_MS 1
`define NS_PER_MS 1000000
`define STEP_BASE_CYCLES ((`STEP_BASE_MS * `NS_PER_MS) / `CLK_PERIOD_NS)

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [bench/regs_checker_properties.sv]
// Bus handshake checker for the system interrupt and sequencing registers
module regs_checker (
	input wire CORE_CLK_IN,
	input wire RESETN_IN,
	input wire S_AXI_AWVALID_IN,
	input wire S_AXI_AWREADY_OUT,
	input wire S_AXI_WVALID_IN,
	input wire S_AXI_WREADY_OUT,
	input wire [1:0] S_AXI_BRESP_OUT,
	input wire S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	input wire S_AXI_ARVALID_IN,
	input wire S_AXI_ARREADY_OUT,
	input wire [31:0] S_AXI_RDATA_OUT,
	input wire S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN
);
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	sequence wr_both;
		S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
	endsequence
	sequence b_soon;
		##[0:1] S_AXI_BVALID_OUT;
	endsequence
	a_b_holds: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
		S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write response dropped");
	a_r_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
		S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data dropped");
	a_rdata_upper: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_write_answered: assert property (wr_both |=> b_soon) else $error("write not answered");
	a_read_answered: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> ##[0:1] S_AXI_RVALID_OUT)
		else $error("read not answered");
	a_write_refused: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
		else $error("write taken while response pending");
	a_read_refused: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
		else $error("read taken while data pending");
	a_ready_pulse: assert property (S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
		else $error("address ready held");
	a_resp_codes: assert property (S_AXI_BVALID_OUT |-> S_AXI_BRESP_OUT inside {2'h0, 2'h2})
		else $error("bad write response code");
endmodule // regs_checker

bind system_irq_enable_sequencing_regs regs_checker u_regs_checker (
	.CORE_CLK_IN(CORE_CLK_IN),
	.RESETN_IN(RESETN_IN),
	.S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
	.S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
	.S_AXI_WVALID_IN(S_AXI_WVALID_IN),
	.S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
	.S_AXI_BRESP_OUT(S_AXI_BRESP_OUT),
	.S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
	.S_AXI_BREADY_IN(S_AXI_BREADY_IN),
	.S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
	.S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
	.S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
	.S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
	.S_AXI_RREADY_IN(S_AXI_RREADY_IN)
);

// [bench/test_system_irq_enable_sequencing_regs.sv]
// Testbench for the system interrupt and sequencing registers
`include "sys_irq_seq_map.vh"

module test_system_irq_enable_sequencing_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic rst_n = 0;
	logic [7:0] awaddr = 0;
	logic [7:0] araddr = 0;
	logic [31:0] wdata = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, en_pin = 0;
	logic [4:0] ev = 0;
	logic [1:0] gpi = 0;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] on, start, lp;
	int failures = 0;
	int compares = 0;
	int st = 0;
	int n, k;
	always #10 clk = ~clk;
	system_irq_enable_sequencing_regs #(.STEP_CYCLES(8)) u_system_irq_enable_sequencing_regs (
		.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
		.SUPPLY_UNDERVOLTAGE_IN(ev[3]), .THERMAL_OFF_IN(ev[2]), .HOT_HIGH_IN(ev[1]),
		.HOT_LOW_IN(ev[0]), .WATCHDOG_INPUT_IN(ev[4]), .ENABLE_PIN_IN(en_pin),
		.GENERAL_INPUT_PIN_IN(gpi), .MASTER_OUTPUT_ON_OUT(on), .MASTER_START_OUT(start),
		.MASTER_LOW_POWER_OUT(lp), .IRQ_OUT(irq));
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
		logic aw, w;
		@(posedge clk);
		awaddr <= {i[5:0], 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1;
		wvalid <= 1;
		aw = 0;
		w = 0;
		while (!(aw && w)) begin
			@(posedge clk);
			if (awvalid && awready === 1) begin
				aw = 1;
				awvalid <= 0;
			end
			if (wvalid && wready === 1) begin
				w = 1;
				wvalid <= 0;
			end
		end
		repeat (st) @(posedge clk);
		bready <= 1;
		do @(posedge clk); while (bvalid !== 1);
		bready <= 0;
		chk(bresp, er);
	endtask
	task rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= {i[5:0], 2'b00};
		arvalid <= 1;
		do @(posedge clk); while (arready !== 1);
		arvalid <= 0;
		repeat (st) @(posedge clk);
		rready <= 1;
		do @(posedge clk); while (rvalid !== 1);
		rready <= 0;
		chk(rdata, {24'h000000, e});
		chk(rresp, er);
	endtask
	task meas(input int b, output int c);
		c = 0;
		while (start[b] !== 1 && c < 400) begin
			@(posedge clk);
			c++;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rd(`IDX_IRQ_MASK, 8'h13, `RESP_OKAY);
		rd(`IDX_ENABLE_CTRL, 8'h00, `RESP_OKAY);
		rd(`IDX_STARTUP_DLY_ONE, 8'h00, `RESP_OKAY);
		st = 3;
		wr(`IDX_IRQ_MASK, 8'hFF, `RESP_OKAY);
		rd(`IDX_IRQ_MASK, 8'h1F, `RESP_OKAY);
		st = 0;
		wr(`IDX_STARTUP_DLY_ONE, 8'hFF, `RESP_OKAY);
		rd(`IDX_STARTUP_DLY_ONE, 8'h9F, `RESP_OKAY);
		wr(`IDX_STARTUP_DLY_TWO, 8'hFF, `RESP_OKAY);
		rd(`IDX_STARTUP_DLY_TWO, 8'h1F, `RESP_OKAY);
		wr(8'h3F, 8'h5A, `RESP_SLVERR);
		rd(8'h3F, 8'h00, `RESP_SLVERR);
		wr(`IDX_ENABLE_CTRL, 8'hAA, `RESP_OKAY);
		repeat (3) @(posedge clk);
		chk(lp, 4'hF);
		chk(on, 4'h0);
		wr(`IDX_ENABLE_CTRL, 8'h55, `RESP_OKAY);
		repeat (3) @(posedge clk);
		chk(lp, 4'h0);
		chk(on, 4'hF);
		wr(`IDX_ENABLE_CTRL, 8'h00, `RESP_OKAY);
		wr(`IDX_INPUT_ASSIGN, 8'h09, `RESP_OKAY);
		gpi <= 2'b01;
		repeat (4) @(posedge clk);
		chk(on, 4'h1);
		gpi <= 2'b10;
		repeat (4) @(posedge clk);
		chk(on, 4'h2);
		wr(`IDX_COND_STATUS, 8'hFF, `RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			ev <= 5'h01 << i;
			repeat (6) @(posedge clk);
			rd(`IDX_COND_STATUS, (8'h01 << i) & 8'h0F, `RESP_OKAY);
			rd(`IDX_IRQ_FLAGS, 8'h01 << i, `RESP_OKAY);
			chk(irq, 1'b0);
			wr(`IDX_IRQ_MASK, ~(8'h01 << i) & 8'h1F, `RESP_OKAY);
			repeat (2) @(posedge clk);
			chk(irq, 1'b1);
			ev <= 5'h00;
			wr(`IDX_IRQ_CLEAR, 8'h01 << i, `RESP_OKAY);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
			wr(`IDX_IRQ_MASK, 8'h1F, `RESP_OKAY);
		end
		// Two 2 ms steps for master two, three for master three, 8 cycles per 1 ms
		wr(`IDX_STARTUP_DLY_ONE, 8'h82, `RESP_OKAY);
		wr(`IDX_STARTUP_DLY_TWO, 8'h03, `RESP_OKAY);
		wr(`IDX_GLOBAL_CTRL, 8'h01, `RESP_OKAY);
		meas(1, n);
		chk(start[0], 1'b1);
		chk(n >= 24 && n <= 36, 1'b1);
		meas(2, k);
		chk(n + k >= 40 && n + k <= 52, 1'b1);
		wr(`IDX_GLOBAL_CTRL, 8'h00, `RESP_OKAY);
		wr(`IDX_STARTUP_DLY_ONE, 8'h02, `RESP_OKAY);
		repeat (4) @(posedge clk);
		chk(start, 4'h0);
		en_pin <= 1;
		meas(1, n);
		chk(n >= 8 && n <= 22, 1'b1);
		// Mid-run reset must clear written enables and restore the mask
		wr(`IDX_ENABLE_CTRL, 8'hFF, `RESP_OKAY);
		repeat (3) @(posedge clk);
		chk({on, lp}, 8'hFF);
		rst_n <= 0;
		repeat (2) @(posedge clk);
		chk({on, start, lp, irq}, 13'h0000);
		rst_n <= 1;
		rd(`IDX_ENABLE_CTRL, 8'h00, `RESP_OKAY);
		rd(`IDX_IRQ_MASK, 8'h13, `RESP_OKAY);
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule // test_system_irq_enable_sequencing_regs
